// File: pkg/ocd_pkg.sv
package ocd_pkg;

    // register addresses on the serial control port
    localparam logic [8:0] OCD_ADDR_COUNTS  = 9'h190;
    localparam logic [8:0] OCD_ADDR_CONTROL = 9'h191;
    localparam logic [8:0] OCD_ADDR_POWER   = 9'h192;

    // reset values
    localparam logic [7:0] OCD_RST_COUNTS  = 8'h77;
    localparam logic [7:0] OCD_RST_CONTROL = 8'h00;
    localparam logic [7:0] OCD_RST_POWER   = 8'h00;
    localparam logic [7:0] OCD_RD_UNMAPPED = 8'h00;

    // divider_cycle_counts fields
    localparam int OCD_LOW_MSB  = 7;
    localparam int OCD_LOW_LSB  = 4;
    localparam int OCD_HIGH_MSB = 3;
    localparam int OCD_HIGH_LSB = 0;

    // divider_control_phase fields
    localparam int OCD_BYPASS_BIT = 7;
    localparam int OCD_IGNORE_BIT = 6;
    localparam int OCD_FORCE_BIT  = 5;
    localparam int OCD_START_BIT  = 4;
    localparam int OCD_PHASE_MSB  = 3;
    localparam int OCD_PHASE_LSB  = 0;

    // channel_power_routing fields
    localparam int OCD_PDOWN_BIT  = 2;
    localparam int OCD_DIRECT_BIT = 1;
    localparam int OCD_DCCOFF_BIT = 0;

    localparam logic [3:0] OCD_CNT_ZERO = 4'h0;
    localparam logic [3:0] OCD_CNT_ONE  = 4'h1;

    typedef enum logic [1:0] {
        OCD_RUN   = 2'b00,
        OCD_DELAY = 2'b01
    } ocd_state_e;

endpackage

// File: src/ocd_regfile.sv
module ocd_regfile
    import ocd_pkg::*;
(
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    // register access
    input  wire logic       wr_en_i,
    input  wire logic       rd_en_i,
    input  wire logic [8:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    // register contents
    output logic      [7:0] counts_o,
    output logic      [7:0] control_o,
    output logic      [7:0] power_o
);

    typedef struct packed {
        logic [7:0] counts;
        logic [7:0] control;
        logic [7:0] power;
        logic [7:0] rdata;
    } ocd_reg_s;

    ocd_reg_s reg_q;
    ocd_reg_s reg_d;

    function automatic logic [7:0] read_mux(input logic [8:0] a, input ocd_reg_s r);
        logic [7:0] v;
        v = OCD_RD_UNMAPPED;
        if (a == OCD_ADDR_COUNTS)
            v = r.counts;
        else if (a == OCD_ADDR_CONTROL)
            v = r.control;
        else if (a == OCD_ADDR_POWER)
            v = r.power;
        return v;
    endfunction

    always_comb
    begin
        reg_d = reg_q;
        if (wr_en_i)
        begin
            if (addr_i == OCD_ADDR_COUNTS)
                reg_d.counts = wdata_i;
            if (addr_i == OCD_ADDR_CONTROL)
                reg_d.control = wdata_i;
            if (addr_i == OCD_ADDR_POWER)
                reg_d.power = wdata_i;
        end
        if (rd_en_i)
            reg_d.rdata = read_mux(addr_i, reg_q);
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            reg_q.counts  <= OCD_RST_COUNTS;
            reg_q.control <= OCD_RST_CONTROL;
            reg_q.power   <= OCD_RST_POWER;
            reg_q.rdata   <= OCD_RD_UNMAPPED;
        end
        else
            reg_q <= reg_d;
    end

    assign rdata_o   = reg_q.rdata;
    assign counts_o  = reg_q.counts;
    assign control_o = reg_q.control;
    assign power_o   = reg_q.power;

endmodule

// File: src/ocd_divider.sv
// Notes on behaviour
// - low lasts low-count plus one cycles
// - high lasts high-count plus one cycles
// - bypass passes input clock to output
// - ignore bit makes alignment requests ignored
// - force bit sets static level, needs ignore
// - start bit picks level after alignment
// - four-bit phase offset, resets to zero
// - power-down parks all three outputs low
// - direct bit routes input clock to outputs
// - global routing bit cancels direct path
// - correction enabled unless disable bit, bypass or power-down set
module ocd_divider
    import ocd_pkg::*;
(
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    // serial control port register access
    input  wire logic       reg_wr_en_i,
    input  wire logic       reg_rd_en_i,
    input  wire logic [8:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // chip-level controls
    input  wire logic       sync_i,
    input  wire logic       route_global_i,
    // channel outputs
    output logic            group_output_a_o,
    output logic            group_output_b_o,
    output logic            group_output_c_o,
    output logic            divider_out_o,
    output logic            channel_off_o,
    output logic            duty_cycle_fix_o
);

    typedef struct packed {
        ocd_state_e state;
        logic       level;
        logic [3:0] cnt;
        logic [3:0] phase_cnt;
        logic [3:0] lo_sh;
        logic [3:0] hi_sh;
        logic       tog;
        logic [2:0] grp;
        logic       div_out;
        logic       off;
        logic       dcc;
    } ocd_div_s;

    ocd_div_s q;
    ocd_div_s d;

    logic [7:0] counts;
    logic [7:0] control;
    logic [7:0] power;

    ocd_regfile u_regs (
        .clock_i   (clock_i),
        .reset_i   (reset_i),
        .wr_en_i   (reg_wr_en_i),
        .rd_en_i   (reg_rd_en_i),
        .addr_i    (reg_addr_i),
        .wdata_i   (reg_wdata_i),
        .rdata_o   (reg_rdata_o),
        .counts_o  (counts),
        .control_o (control),
        .power_o   (power)
    );

    logic       bypass;
    logic       ignore_sync;
    logic       force_hi;
    logic       start_hi;
    logic [3:0] phase;
    logic       pdown;
    logic       direct_eff;
    logic       sync_go;
    logic [3:0] lo_reg;
    logic [3:0] hi_reg;

    assign lo_reg      = counts[OCD_LOW_MSB:OCD_LOW_LSB];
    assign hi_reg      = counts[OCD_HIGH_MSB:OCD_HIGH_LSB];
    assign bypass      = control[OCD_BYPASS_BIT];
    assign ignore_sync = control[OCD_IGNORE_BIT];
    assign force_hi    = control[OCD_FORCE_BIT] & control[OCD_IGNORE_BIT];
    assign start_hi    = control[OCD_START_BIT];
    assign phase       = control[OCD_PHASE_MSB:OCD_PHASE_LSB];
    assign pdown       = power[OCD_PDOWN_BIT];
    assign direct_eff  = power[OCD_DIRECT_BIT] & ~route_global_i;
    assign sync_go     = sync_i & ~ignore_sync;

    always_comb
    begin
        d     = q;
        d.tog = ~q.tog;
        if (sync_go)
        begin
            // restart with fresh counts at the chosen level
            d.lo_sh = lo_reg;
            d.hi_sh = hi_reg;
            d.level = start_hi;
            if (phase == OCD_CNT_ZERO)
            begin
                d.state = OCD_RUN;
                d.cnt   = start_hi ? hi_reg : lo_reg;
            end
            else
            begin
                d.state     = OCD_DELAY;
                d.phase_cnt = 4'(phase - OCD_CNT_ONE);
            end
        end
        else
        begin
            unique case (q.state)
                OCD_DELAY:
                begin
                    if (q.phase_cnt == OCD_CNT_ZERO)
                    begin
                        d.state = OCD_RUN;
                        d.cnt   = q.level ? q.hi_sh : q.lo_sh;
                    end
                    else
                        d.phase_cnt = 4'(q.phase_cnt - OCD_CNT_ONE);
                end
                OCD_RUN:
                begin
                    if (q.cnt != OCD_CNT_ZERO)
                        d.cnt = 4'(q.cnt - OCD_CNT_ONE);
                    else if (q.level)
                    begin
                        // period boundary: take new counts
                        d.lo_sh = lo_reg;
                        d.hi_sh = hi_reg;
                        d.level = 1'b0;
                        d.cnt   = lo_reg;
                    end
                    else
                    begin
                        d.level = 1'b1;
                        d.cnt   = q.hi_sh;
                    end
                end
                default:
                begin
                    d.state = OCD_RUN;
                    d.cnt   = OCD_CNT_ZERO;
                end
            endcase
        end
        if (force_hi)
            d.div_out = 1'b1;
        else if (bypass)
            d.div_out = d.tog;
        else
            d.div_out = d.level;
        if (pdown)
            d.grp = 3'h0;
        else if (direct_eff)
            d.grp = {3{d.tog}};
        else
            d.grp = {3{d.div_out}};
        d.off = pdown;
        d.dcc = ~power[OCD_DCCOFF_BIT] & ~bypass & ~pdown;
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            q.state     <= OCD_RUN;
            q.level     <= 1'b0;
            q.cnt       <= OCD_RST_COUNTS[OCD_LOW_MSB:OCD_LOW_LSB];
            q.phase_cnt <= OCD_CNT_ZERO;
            q.lo_sh     <= OCD_RST_COUNTS[OCD_LOW_MSB:OCD_LOW_LSB];
            q.hi_sh     <= OCD_RST_COUNTS[OCD_HIGH_MSB:OCD_HIGH_LSB];
            q.tog       <= 1'b0;
            q.grp       <= 3'h0;
            q.div_out   <= 1'b0;
            q.off       <= 1'b0;
            q.dcc       <= 1'b0;
        end
        else
            q <= d;
    end

    assign group_output_a_o = q.grp[0];
    assign group_output_b_o = q.grp[1];
    assign group_output_c_o = q.grp[2];
    assign divider_out_o    = q.div_out;
    assign channel_off_o    = q.off;
    assign duty_cycle_fix_o = q.dcc;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    sequence s_low_run;
        q.state == OCD_RUN && !q.level && q.cnt != OCD_CNT_ZERO && !sync_go;
    endsequence
    sequence s_high_run;
        q.state == OCD_RUN && q.level && q.cnt != OCD_CNT_ZERO && !sync_go;
    endsequence

    property p_low_hold;
        s_low_run |=> !q.level && q.cnt == 4'($past(q.cnt) - OCD_CNT_ONE);
    endproperty
    a_low_hold: assert property (p_low_hold) else $error("low phase ended early");

    property p_high_hold;
        s_high_run |=> q.level && q.cnt == 4'($past(q.cnt) - OCD_CNT_ONE);
    endproperty
    a_high_hold: assert property (p_high_hold) else $error("high phase ended early");

    sequence s_bypass_two;
        bypass && !force_hi ##1 bypass && !force_hi;
    endsequence
    property p_bypass;
        s_bypass_two |=> q.div_out != $past(q.div_out);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not following input clock");

    property p_ignore;
        ignore_sync && sync_i && q.state == OCD_RUN && q.cnt != OCD_CNT_ZERO
            |=> q.cnt == 4'($past(q.cnt) - OCD_CNT_ONE);
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored alignment disturbed divider");

    property p_force;
        force_hi |=> q.div_out;
    endproperty
    a_force: assert property (p_force) else $error("forced high not applied");

    property p_start;
        sync_go && phase == OCD_CNT_ZERO |=> q.level == $past(start_hi) && q.state == OCD_RUN;
    endproperty
    a_start: assert property (p_start) else $error("wrong start level");

    sequence s_sync_three;
        sync_go && phase == 4'h3;
    endsequence
    property p_phase;
        s_sync_three ##1 (!sync_go) [*3] |-> q.state == OCD_DELAY ##1 q.state == OCD_RUN;
    endproperty
    a_phase: assert property (p_phase) else $error("phase offset delay wrong");

    property p_pdown;
        pdown |=> q.grp == 3'h0 && q.off;
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down outputs not parked");

    sequence s_direct_two;
        direct_eff && !pdown ##1 direct_eff && !pdown;
    endsequence
    property p_direct;
        s_direct_two |=> q.grp[0] != $past(q.grp[0]) && q.grp == {3{q.grp[0]}};
    endproperty
    a_direct: assert property (p_direct) else $error("direct path not routed");

    property p_nodirect;
        !direct_eff && !pdown |=> q.grp == {3{q.div_out}};
    endproperty
    a_nodirect: assert property (p_nodirect) else $error("outputs not from divider");

    property p_dcc;
        power[OCD_DCCOFF_BIT] |=> !q.dcc;
    endproperty
    a_dcc: assert property (p_dcc) else $error("correction not disabled");

    property p_shadow;
        !sync_go && !(q.state == OCD_RUN && q.level && q.cnt == OCD_CNT_ZERO)
            |=> q.lo_sh == $past(q.lo_sh) && q.hi_sh == $past(q.hi_sh);
    endproperty
    a_shadow: assert property (p_shadow) else $error("counts changed mid period");

endmodule

// File: verif/ocd_clock_sink.sv
module ocd_clock_sink
(
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    // received channel clock
    input  wire logic       level_i,
    // measured run lengths in input clock cycles
    output logic      [7:0] last_low_o,
    output logic      [7:0] last_high_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       prev_q;
    logic [7:0] run_q;

    // a receiver only sees levels; it times each low and high run
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            prev_q      <= 1'b0;
            run_q       <= 8'h00;
            last_low_o  <= 8'h00;
            last_high_o <= 8'h00;
        end
        else if (level_i != prev_q)
        begin
            if (prev_q)
                last_high_o <= run_q;
            else
                last_low_o <= run_q;
            run_q  <= 8'h01;
            prev_q <= level_i;
        end
        else
            run_q <= run_q + 8'h01;
    end
endmodule

// File: verif/output_channel_clock_divider_bench.sv
module output_channel_clock_divider_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import ocd_pkg::*;

    logic       clock_i = 1'b0;
    logic       reset_i = 1'b1;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    logic [8:0] addr = 9'h000;
    logic [7:0] wdata = 8'h00;
    logic       sync = 1'b0;
    logic       route = 1'b0;
    logic [7:0] rdata;
    logic       out_a, out_b, out_c, div_out, chan_off, dcc_on;
    logic [7:0] last_low, last_high, lfsr_q, val;
    logic       probe_sel = 1'b0;
    logic       probe;
    int         num_errors = 0;
    int         total_checks = 0;
    int         n, k;

    assign probe = probe_sel ? out_a : div_out;

    initial forever #12.5 clock_i = ~clock_i;

    ocd_divider dut (.clock_i(clock_i), .reset_i(reset_i), .reg_wr_en_i(wr_en), .reg_rd_en_i(rd_en),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .sync_i(sync),
        .route_global_i(route), .group_output_a_o(out_a), .group_output_b_o(out_b),
        .group_output_c_o(out_c), .divider_out_o(div_out), .channel_off_o(chan_off),
        .duty_cycle_fix_o(dcc_on));

    ocd_clock_sink sink (.clock_i(clock_i), .reset_i(reset_i), .level_i(out_a),
        .last_low_o(last_low), .last_high_o(last_high));

    function automatic logic [7:0] ocd_lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [8:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clock_i);
        wr_en <= 1'b0;
    endtask

    task automatic reg_read(input string name, input logic [8:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clock_i);
        rd_en <= 1'b0;
        #1;
        check(name, exp, rdata);
    endtask

    task automatic pulse_sync();
        @(posedge clock_i);
        sync <= 1'b1;
        @(posedge clock_i);
        sync <= 1'b0;
        #1;
    endtask

    // bounded wait for the divider level
    task automatic wait_level(input logic lvl);
        for (int i = 0; i < 40 && div_out !== lvl; i++)
        begin
            @(posedge clock_i);
            #1;
        end
        if (div_out !== lvl)
        begin
            num_errors++;
            $display("ERROR wait_level expected %b seen %b", lvl, div_out);
            conclude();
        end
    endtask

    task automatic run_length(input logic lvl, output int len);
        len = 0;
        while (div_out === lvl && len < 64)
        begin
            len++;
            @(posedge clock_i);
            #1;
        end
    endtask

    task automatic toggles(output int cnt);
        logic p;
        cnt = 0;
        // let the new mode settle before the first reference sample
        @(posedge clock_i);
        #1;
        for (int i = 0; i < 8; i++)
        begin
            p = probe;
            @(posedge clock_i);
            #1;
            if (probe !== p)
                cnt++;
        end
    endtask

    initial
    begin
        repeat (100000) @(posedge clock_i);
        num_errors++;
        $display("ERROR watchdog expected done seen hang");
        conclude();
    end

    initial
    begin
        lfsr_q = 8'h30;
        repeat (5) @(posedge clock_i);
        reset_i <= 1'b0;
        reg_read("counts reset", OCD_ADDR_COUNTS, OCD_RST_COUNTS);
        reg_read("control reset", OCD_ADDR_CONTROL, OCD_RST_CONTROL);
        reg_read("power reset", OCD_ADDR_POWER, OCD_RST_POWER);
        check("dcc default", 8'h01, {7'h00, dcc_on});
        // counts written mid-run, corners then random
        for (k = 0; k < 4; k++)
        begin
            lfsr_q = ocd_lfsr(lfsr_q);
            val = (k == 0) ? 8'h00 : (k == 1) ? 8'hF0 : lfsr_q;
            reg_write(OCD_ADDR_COUNTS, val);
            repeat (102) @(posedge clock_i);
            #1;
            check("low run", {4'h0, val[7:4]} + 8'h01, last_low);
            check("high run", {4'h0, val[3:0]} + 8'h01, last_high);
        end
        reg_write(OCD_ADDR_COUNTS, 8'h77);
        // obeyed alignment: start level then phase delay
        for (k = 0; k < 4; k++)
        begin
            val = {3'b000, k[0], 2'b00, k[1], k[1]};
            reg_write(OCD_ADDR_CONTROL, val);
            wait_level(val[4]);
            wait_level(~val[4]);
            pulse_sync();
            wait_level(val[4]);
            run_length(val[4], n);
            check("start run", {4'h0, val[3:0]} + 8'h08, 8'(n));
        end
        // ignored alignment keeps the low run going
        reg_write(OCD_ADDR_CONTROL, 8'h50);
        wait_level(1'b1);
        wait_level(1'b0);
        pulse_sync();
        run_length(1'b0, n);
        check("sync ignored", 8'h01, {7'h00, n >= 5});
        reg_write(OCD_ADDR_CONTROL, 8'h60);
        repeat (2) @(posedge clock_i);
        pulse_sync();
        run_length(1'b1, n);
        check("forced high", 8'h40, 8'(n));
        reg_write(OCD_ADDR_CONTROL, 8'h80);
        toggles(n);
        check("bypass toggles", 8'h08, 8'(n));
        reg_write(OCD_ADDR_CONTROL, 8'h00);
        reg_write(OCD_ADDR_POWER, 8'h02);
        probe_sel = 1'b1;
        toggles(n);
        check("direct toggles", 8'h08, 8'(n));
        check("group b c", {6'h00, out_a, out_a}, {6'h00, out_b, out_c});
        @(posedge clock_i);
        route <= 1'b1;
        repeat (3) @(posedge clock_i);
        #1;
        n = 0;
        for (k = 0; k < 8; k++)
        begin
            n += (out_a === div_out);
            @(posedge clock_i);
            #1;
        end
        check("route global", 8'h08, 8'(n));
        reg_write(OCD_ADDR_POWER, 8'h04);
        repeat (2) @(posedge clock_i);
        #1;
        check("power down", 8'h02, {5'h00, out_a | out_b | out_c, chan_off, dcc_on});
        reg_write(OCD_ADDR_POWER, 8'h01);
        repeat (2) @(posedge clock_i);
        #1;
        check("dcc off", 8'h00, {7'h00, dcc_on});
        reg_write(OCD_ADDR_CONTROL, 8'h0F);
        reg_read("phase field", OCD_ADDR_CONTROL, 8'h0F);
        reg_write(9'h1FF, 8'hAA);
        reg_read("unmapped", 9'h1FF, OCD_RD_UNMAPPED);
        reg_read("power kept", OCD_ADDR_POWER, 8'h01);
        conclude();
    end
endmodule
